// file: qrc_quad_read.sv
// Quad I/O read sequencer with its read-data buffer
//
// Overview of operation
// R1 - EBh: quad address/data, four dummies
// R2 - EBh accepted only with quad permit
// R3 - Mode byte follows address; low nibble ignored
// R4 - Skip code 10 drops next opcode
// R5 - Other skip code restores opcode decoding
// R6 - Host exits with ones on IO0
// R7 - Host releases IO before first data
// R8 - Wrap confines EBh to aligned section
// R9 - Wrapped burst loops until chip select
// R10 - Wrap setting: disable bit, two length bits
// R11 - Four-wire mode dummies from read parameter
// R12 - Four-wire dummy count resets to two
// R13 - Four-wire mode byte counts as dummies
// R14 - Opcode skip works in four-wire mode
// R15 - No wrapping in four-wire mode
// R16 - ECh always takes 32-bit address
// R17 - ECh only in standard mode
// R18 - Wrap setting applies to ECh too
// R19 - E7h: even address, two dummies
// R20 - E7h accepted only with quad permit
// R21 - E7h skip code also drops opcode
// R22 - Address 24 or 32 bits by mode
// R23 - Wrap disabled after any reset
// R24 - IO3 is nibble MSB, high nibble first
// R25 - Unwrapped reads run on sequentially
`timescale 1ns/1ps
`default_nettype none

module qrc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_srst,
    input  wire logic             i_flush,
    // Fill side
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_ptr_q;
    logic [AW:0]      rd_ptr_q;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign count       = wr_ptr_q - rd_ptr_q;
    assign o_in_ready  = (count != (AW+1)'(DEPTH));
    assign o_out_valid = (count != '0);
    assign o_out_data  = mem_q[rd_ptr_q[AW-1:0]];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = i_out_ready & o_out_valid;

    always_ff @(posedge i_clock) begin
        if (push) begin
            mem_q[wr_ptr_q[AW-1:0]] <= i_in_data;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst || i_flush) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end
endmodule : qrc_fifo

module qrc_quad_read (
    // Clock and reset
    input  wire logic                 i_clock,
    input  wire logic                 i_srst,
    // Serial link pins
    input  wire logic                 i_cs_n,
    input  wire logic                 i_sck,
    input  wire logic [3:0]           i_io,
    output logic [3:0]                o_io,
    output logic [3:0]                o_io_oe,
    // Configuration
    input  wire logic                 i_quad_io_permit_bit,
    input  wire logic                 i_four_wire_command_mode,
    input  wire logic                 i_four_byte_addr_mode,
    input  wire logic                 i_wrap_load,
    input  wire logic [2:0]           i_wrap_setting_bits,
    input  wire logic                 i_read_param_load,
    input  wire logic [1:0]           i_read_param,
    input  wire logic                 i_reset_cmd,
    // Memory array read port
    output qrc_pkg::qrc_mem_req_s     o_mem_req,
    input  wire logic                 i_mem_req_ready,
    input  wire logic                 i_mem_rsp_valid,
    input  wire logic [7:0]           i_mem_rsp_data,
    // Status
    output logic                      o_continuous_read,
    output logic [2:0]                o_wrap_setting_bits,
    output logic                      o_underrun
);
    import qrc_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] next_addr(input logic [31:0] a,
                                              input logic        wrap_on,
                                              input logic [1:0]  len);
        logic [7:0] mask;
        logic [7:0] low;
        mask = (WRAP_MIN_LEN << len) - 8'h01;
        low  = (a[7:0] & ~mask) | ((a[7:0] + 8'h01) & mask);
        return wrap_on ? {a[31:8], low} : a + 32'h1;
    endfunction : next_addr

    function automatic qrc_ctx_s decode_ctx(input logic [7:0] op,
                                            input logic       four_wire_command_mode,
                                            input logic       four_byte,
                                            input logic [1:0] param);
        qrc_ctx_s c;
        // R16 R22 address width
        c.addr_clks  = (op == OP_QUAD_READ_4B || four_byte) ? ADDR_CLKS_4B
                                                             : ADDR_CLKS_3B;
        // R11 R13 mode byte already covers two of the dummies
        if (four_wire_command_mode) begin
            c.dummy_clks = {1'b0, param, 1'b0};
        // R19 word read dummies
        end else if (op == OP_WORD_READ) begin
            c.dummy_clks = DUMMY_WORD_SPI;
        // R1 quad read dummies
        end else begin
            c.dummy_clks = DUMMY_QUAD_SPI;
        end
        // R15 no wrap in four-wire mode
        c.wrap_ok = ~four_wire_command_mode;
        return c;
    endfunction : decode_ctx

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] cs_sync_q;
    logic [2:0] sck_sync_q;
    logic [3:0] io_s1_q;
    logic [3:0] io_s2_q;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            cs_sync_q  <= 3'h7;
            sck_sync_q <= 3'h0;
            io_s1_q    <= 4'h0;
            io_s2_q    <= 4'h0;
        end else begin
            cs_sync_q  <= {cs_sync_q[1:0], i_cs_n};
            sck_sync_q <= {sck_sync_q[1:0], i_sck};
            io_s1_q    <= i_io;
            io_s2_q    <= io_s1_q;
        end
    end

    logic cs_high;
    logic sck_rise;
    logic sck_fall;

    assign cs_high  = cs_sync_q[1];
    assign sck_rise = sck_sync_q[1] & ~sck_sync_q[2];
    assign sck_fall = ~sck_sync_q[1] & sck_sync_q[2];

    // ------------------------------------------------------------------
    // Configuration held across transactions
    // ------------------------------------------------------------------
    logic [2:0] wrap_q;
    logic [1:0] read_param_q;

    always_ff @(posedge i_clock) begin
        // R23 R12 defaults on either reset
        if (i_srst || i_reset_cmd) begin
            wrap_q       <= WRAP_SETTING_RST;
            read_param_q <= READ_PARAM_RST;
        end else begin
            // R10 disable bit plus two length bits
            if (i_wrap_load) begin
                wrap_q <= i_wrap_setting_bits;
            end
            if (i_read_param_load) begin
                read_param_q <= i_read_param;
            end
        end
    end

    // ------------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------------
    qrc_state_e  state_q;
    qrc_ctx_s    ctx_q;
    logic [3:0]  cnt_q;
    logic [31:0] sh_q;
    logic [31:0] sh_nib;
    logic [31:0] sh_bit;
    logic [3:0]  cnt_inc;
    logic        cont_q;
    logic        cmd_last;
    logic [7:0]  opcode;
    logic        cmd_ok;
    logic        addr_done;
    logic        mode_done;
    logic [31:0] start_addr;

    // R24 IO3 carries the nibble MSB
    assign sh_nib    = {sh_q[27:0], io_s2_q};
    assign sh_bit    = {sh_q[30:0], io_s2_q[0]};
    assign cnt_inc   = cnt_q + 4'h1;
    assign cmd_last  = cnt_inc == (i_four_wire_command_mode ? CMD_CLKS_QPI : CMD_CLKS_SPI);
    assign opcode    = i_four_wire_command_mode ? sh_nib[7:0] : sh_bit[7:0];
    assign addr_done = (state_q == ST_ADDR) && sck_rise && (cnt_inc == ctx_q.addr_clks);
    assign mode_done = (state_q == ST_MODE) && sck_rise && (cnt_inc == MODE_CLKS);
    assign start_addr = (ctx_q.addr_clks == ADDR_CLKS_4B) ? sh_nib : {8'h00, sh_nib[23:0]};

    always_comb begin
        unique case (opcode)
            // R2 R1 needs quad permit
            OP_QUAD_READ:    cmd_ok = i_quad_io_permit_bit;
            // R17 standard mode only
            OP_QUAD_READ_4B: cmd_ok = i_quad_io_permit_bit & ~i_four_wire_command_mode;
            // R20 needs quad permit
            OP_WORD_READ:    cmd_ok = i_quad_io_permit_bit & ~i_four_wire_command_mode;
            default:         cmd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state_q <= ST_IDLE;
            cnt_q   <= 4'h0;
            sh_q    <= 32'h0;
            ctx_q   <= '0;
        end else if (cs_high) begin
            state_q <= ST_IDLE;
            cnt_q   <= 4'h0;
        end else begin
            unique case (state_q)
                // R4 R14 R21 skip straight to the address
                ST_IDLE: begin
                    cnt_q   <= 4'h0;
                    state_q <= cont_q ? ST_ADDR : ST_CMD;
                end
                ST_CMD: if (sck_rise) begin
                    sh_q  <= i_four_wire_command_mode ? sh_nib : sh_bit;
                    cnt_q <= cnt_inc;
                    if (cmd_last) begin
                        cnt_q   <= 4'h0;
                        ctx_q   <= decode_ctx(opcode, i_four_wire_command_mode,
                                              i_four_byte_addr_mode, read_param_q);
                        state_q <= cmd_ok ? ST_ADDR : ST_IGNORE;
                    end
                end
                ST_ADDR: if (sck_rise) begin
                    sh_q  <= sh_nib;
                    cnt_q <= cnt_inc;
                    if (addr_done) begin
                        cnt_q   <= 4'h0;
                        state_q <= ST_MODE;
                    end
                end
                ST_MODE: if (sck_rise) begin
                    sh_q  <= sh_nib;
                    cnt_q <= cnt_inc;
                    if (mode_done) begin
                        cnt_q   <= 4'h0;
                        // R13 default four-wire count gives data next
                        state_q <= (ctx_q.dummy_clks == 4'h0) ? ST_DATA : ST_DUMMY;
                    end
                end
                ST_DUMMY: if (sck_rise) begin
                    cnt_q <= cnt_inc;
                    if (cnt_inc == ctx_q.dummy_clks) begin
                        state_q <= ST_DATA;
                    end
                end
                ST_DATA, ST_IGNORE: begin
                    cnt_q <= 4'h0;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Continuous-read flag, read from the mode byte's upper nibble
    always_ff @(posedge i_clock) begin
        if (i_srst || i_reset_cmd) begin
            cont_q <= 1'b0;
        // R3 R4 R5 only bits 5:4 matter
        end else if (mode_done) begin
            cont_q <= (sh_q[1:0] == OPCODE_SKIP_CODE);
        end
    end

    // ------------------------------------------------------------------
    // Array prefetch into the buffer
    // ------------------------------------------------------------------
    logic         fetch_en_q;
    logic         pend_q;
    logic         stale_q;
    logic [31:0]  fetch_addr_q;
    qrc_mem_req_s req_q;
    logic         wrap_on;
    logic         fifo_in_ready;
    logic         fifo_out_valid;
    logic [7:0]   fifo_out_data;
    logic         push;
    logic         pop;

    // R8 R18 R15 wrap only when enabled and in standard mode
    assign wrap_on = ~wrap_q[WRAP_DISABLE_POS] & ctx_q.wrap_ok;
    assign push    = i_mem_rsp_valid & pend_q & ~stale_q & fetch_en_q;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            fetch_en_q   <= 1'b0;
            pend_q       <= 1'b0;
            stale_q      <= 1'b0;
            fetch_addr_q <= 32'h0;
            req_q        <= '0;
        end else begin
            if (req_q.valid && i_mem_req_ready) begin
                req_q.valid <= 1'b0;
                pend_q      <= 1'b1;
                // R9 R25 step within section or onward
                if (!stale_q) begin
                    fetch_addr_q <= next_addr(fetch_addr_q, wrap_on, wrap_q[2:1]);
                end
            end else if (fetch_en_q && !req_q.valid && !pend_q && fifo_in_ready) begin
                req_q.valid <= 1'b1;
                req_q.addr  <= fetch_addr_q;
            end
            if (i_mem_rsp_valid && pend_q) begin
                pend_q  <= 1'b0;
                stale_q <= 1'b0;
            end
            // Reply still owed after chip select rises is dropped
            if (cs_high) begin
                fetch_en_q <= 1'b0;
                if (pend_q || req_q.valid) begin
                    stale_q <= 1'b1;
                end
            end else if (addr_done) begin
                fetch_en_q   <= 1'b1;
                fetch_addr_q <= start_addr;
            end
        end
    end

    assign o_mem_req = req_q;

    qrc_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clock     (i_clock),
        .i_srst      (i_srst),
        .i_flush     (cs_high),
        .i_in_valid  (push),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (i_mem_rsp_data),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (pop),
        .o_out_data  (fifo_out_data)
    );

    // ------------------------------------------------------------------
    // Data output on falling serial clock
    // ------------------------------------------------------------------
    logic       nib_hi_q;
    logic [3:0] low_nib_q;
    logic       underrun_q;

    assign pop = (state_q == ST_DATA) && !cs_high && sck_fall && nib_hi_q;

    always_ff @(posedge i_clock) begin
        if (i_srst || cs_high) begin
            o_io_oe   <= 4'h0;
            o_io      <= 4'h0;
            nib_hi_q  <= 1'b1;
            low_nib_q <= 4'h0;
        // R7 drive only from the first data falling edge
        end else if (state_q == ST_DATA && sck_fall) begin
            o_io_oe  <= 4'hF;
            nib_hi_q <= ~nib_hi_q;
            // R24 high nibble goes first
            if (nib_hi_q) begin
                o_io      <= fifo_out_valid ? fifo_out_data[7:4] : IO_IDLE_NIBBLE;
                low_nib_q <= fifo_out_valid ? fifo_out_data[3:0] : IO_IDLE_NIBBLE;
            end else begin
                o_io <= low_nib_q;
            end
        end
    end

    // Sticky until reset: the link cannot stall, so a late array shows here
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            underrun_q <= 1'b0;
        end else if (pop && !fifo_out_valid) begin
            underrun_q <= 1'b1;
        end
    end

    assign o_continuous_read   = cont_q;
    assign o_wrap_setting_bits = wrap_q;
    assign o_underrun          = underrun_q;

endmodule : qrc_quad_read

`default_nettype wire

// file: qrc_pkg.sv
// Shared constants and types for the quad I/O read command sequencer
`default_nettype none
package qrc_pkg;

    // ------------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_QUAD_READ    = 8'hEB;
    localparam logic [7:0] OP_QUAD_READ_4B = 8'hEC;
    localparam logic [7:0] OP_WORD_READ    = 8'hE7;

    // ------------------------------------------------------------------
    // Phase lengths in serial clocks
    // ------------------------------------------------------------------
    localparam logic [3:0] CMD_CLKS_SPI    = 4'h8;
    localparam logic [3:0] CMD_CLKS_QPI    = 4'h2;
    localparam logic [3:0] ADDR_CLKS_3B    = 4'h6;
    localparam logic [3:0] ADDR_CLKS_4B    = 4'h8;
    localparam logic [3:0] MODE_CLKS       = 4'h2;
    localparam logic [3:0] DUMMY_QUAD_SPI  = 4'h4;
    localparam logic [3:0] DUMMY_WORD_SPI  = 4'h2;

    // ------------------------------------------------------------------
    // Mode byte and configuration fields
    // ------------------------------------------------------------------
    localparam logic [1:0] OPCODE_SKIP_CODE = 2'h2;
    localparam logic [1:0] READ_PARAM_RST   = 2'h0;
    localparam logic [2:0] WRAP_SETTING_RST = 3'h1;
    localparam int         WRAP_DISABLE_POS = 0;
    localparam logic [7:0] WRAP_MIN_LEN     = 8'h08;
    localparam logic [3:0] IO_IDLE_NIBBLE   = 4'hF;

    // ------------------------------------------------------------------
    // Buffer shape
    // ------------------------------------------------------------------
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 8;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_CMD    = 3'h1,
        ST_ADDR   = 3'h2,
        ST_MODE   = 3'h3,
        ST_DUMMY  = 3'h4,
        ST_DATA   = 3'h5,
        ST_IGNORE = 3'h6
    } qrc_state_e;

    typedef struct packed {
        logic [3:0] addr_clks;
        logic [3:0] dummy_clks;
        logic       wrap_ok;
    } qrc_ctx_s;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } qrc_mem_req_s;

endpackage : qrc_pkg
`default_nettype wire

// file: qrc_quad_read_sva.sv
// Port checker for the quad read sequencer
`timescale 1ns/1ps
`default_nettype none
module qrc_quad_read_sva (
    // Clock and reset
    input wire logic                  i_clock,
    input wire logic                  i_srst,
    // Watched ports
    input wire logic                  i_cs_n,
    input wire logic                  i_sck,
    input wire logic                  i_quad_io_permit_bit,
    input wire logic                  i_wrap_load,
    input wire logic [2:0]            i_wrap_setting_bits,
    input wire logic                  i_reset_cmd,
    input wire logic                  i_mem_req_ready,
    input wire logic [3:0]            o_io,
    input wire logic [3:0]            o_io_oe,
    input wire qrc_pkg::qrc_mem_req_s o_mem_req,
    input wire logic                  o_continuous_read,
    input wire logic [2:0]            o_wrap_setting_bits
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);

    chk_wrap_rst_val :
    assert property ($fell(i_srst) |-> o_wrap_setting_bits == 3'h1 && !o_continuous_read)
        else $error("wrap bits not at default after reset");
    chk_reset_cmd_val :
    assert property (i_reset_cmd |=> o_wrap_setting_bits == 3'h1 && !o_continuous_read)
        else $error("reset command left state");
    chk_wrap_load_copy :
    assert property (i_wrap_load && !i_reset_cmd |=> o_wrap_setting_bits == $past(i_wrap_setting_bits))
        else $error("wrap setting not loaded");
    chk_oe_four_lines :
    assert property (o_io_oe == 4'h0 || o_io_oe == 4'hF)
        else $error("output enables differ");
    chk_oe_cs_off :
    assert property (i_cs_n [*6] |-> o_io_oe == 4'h0)
        else $error("driving while deselected");
    chk_permit_refuse :
    assert property ((!i_quad_io_permit_bit) [*8] |-> o_io_oe == 4'h0)
        else $error("driving without quad permit");
    chk_drive_on_fall :
    assert property ($rose(o_io_oe[0]) |-> !i_sck)
        else $error("drive started with clock high");
    chk_nibble_stands :
    assert property ($changed(o_io) && $past(o_io_oe) == 4'hF && o_io_oe == 4'hF |-> !i_sck)
        else $error("nibble changed with clock high");
    chk_mem_req_hold :
    assert property (o_mem_req.valid && !i_mem_req_ready |=>
                     o_mem_req.valid && $stable(o_mem_req.addr))
        else $error("array request withdrawn");
    chk_cont_cause :
    assert property ($changed(o_continuous_read) |-> !$past(i_cs_n, 3) || $past(i_reset_cmd))
        else $error("continuous flag changed outside a frame");
endmodule : qrc_quad_read_sva
`default_nettype wire

// file: qrc_host_model.sv
// Host quad SPI controller model on the serial link
`timescale 1ns/1ps
`default_nettype none
module qrc_host_model (
    // Link pins
    output var logic       o_cs_n,
    output var logic       o_sck,
    output var logic [3:0] o_io,
    output var logic       o_io_oe,
    input  wire logic [3:0] i_io_wire
);
    logic [7:0] got;
    event       byte_ev;

    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_io = 4'hF;
        o_io_oe = 1'b0;
    end

    // Mode 0: set while low, taken on the rise, clock idles low
    task automatic tick(input logic [3:0] v);
        o_io = v;
        #62.5;
        o_sck = 1'b1;
        #62.5;
        o_sck = 1'b0;
    endtask : tick

    task automatic xfer(input logic [7:0] op, input bit wo, input bit four_wire_command_mode, input int an,
                        input logic [31:0] a, input logic [7:0] m, input int dm, input int n);
        int i;
        o_cs_n = 1'b0;
        o_io_oe = 1'b1;
        #40;
        // opcode on IO0, or two nibbles in four-wire mode
        if (wo && four_wire_command_mode) begin
            tick(op[7:4]);
            tick(op[3:0]);
        end else if (wo) begin
            for (i = 7; i >= 0; i--) tick({3'h7, op[i]});
        end
        for (i = an - 1; i >= 0; i--) tick(a[4*i +: 4]);
        // mode byte right behind the address
        tick(m[7:4]);
        tick(m[3:0]);
        // let go before the first data fall
        o_io_oe = 1'b0;
        for (i = 0; i < dm; i++) tick(o_io);
        for (i = 0; i < 2 * n; i++) begin
            #62.5;
            got = {got[3:0], i_io_wire};
            o_sck = 1'b1;
            #62.5;
            o_sck = 1'b0;
            if (i[0]) ->byte_ev;
        end
        #62.5;
        o_cs_n = 1'b1;
        #250;
    endtask : xfer
endmodule : qrc_host_model
`default_nettype wire

// file: qrc_quad_read_tb.sv
// Self-checking bench for the quad read sequencer
`timescale 1ns/1ps
`default_nettype none
module qrc_quad_read_tb;
    import qrc_pkg::*;
    logic         i_clock, i_srst, cs_n, sck, h_oe, permit, four_wire_command_mode, fb, wload, pload, rcmd;
    logic         mrdy, mval, acc, o_cont, o_under, oe_seen;
    logic [3:0]   h_io, io_w, o_io, o_io_oe;
    logic [2:0]   wbits, o_wbits;
    logic [1:0]   param;
    logic [7:0]   mdat;
    logic [31:0]  lf, acc_a;
    qrc_mem_req_s req;
    logic [7:0]   exp_q[$];
    int           err_total, compares, cyc, p;

    qrc_quad_read i_qrc_quad_read (.i_clock(i_clock), .i_srst(i_srst), .i_cs_n(cs_n),
        .i_sck(sck), .i_io(io_w), .o_io(o_io), .o_io_oe(o_io_oe),
        .i_quad_io_permit_bit(permit), .i_four_wire_command_mode(four_wire_command_mode),
        .i_four_byte_addr_mode(fb), .i_wrap_load(wload), .i_wrap_setting_bits(wbits),
        .i_read_param_load(pload), .i_read_param(param), .i_reset_cmd(rcmd),
        .o_mem_req(req), .i_mem_req_ready(mrdy), .i_mem_rsp_valid(mval),
        .i_mem_rsp_data(mdat), .o_continuous_read(o_cont), .o_wrap_setting_bits(o_wbits),
        .o_underrun(o_under));
    qrc_host_model i_qrc_host_model (.o_cs_n(cs_n), .o_sck(sck), .o_io(h_io),
        .o_io_oe(h_oe), .i_io_wire(io_w));

    // Released lines show the inverse of their last value
    assign io_w = (o_io_oe == 4'hF) ? o_io : (h_oe ? h_io : ~h_io);

    initial i_clock = 1'b0;
    always #2.5 i_clock = ~i_clock;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [7:0] mem_f(input logic [31:0] x);
        return x[7:0] ^ x[15:8] ^ 8'hA5;
    endfunction : mem_f

    task automatic summarize();
        if (err_total == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    // Array model with random stalls; one reply a cycle after acceptance
    always @(posedge i_clock) begin
        acc = (req.valid === 1'b1) && mrdy;
        acc_a = req.addr;
        cyc++;
        if (o_io_oe !== 4'h0) oe_seen = 1'b1;
        #1;
        lf = lfsr(lf);
        mrdy = lf[0];
        mval = acc;
        mdat = mem_f(acc_a);
        if (cyc == 40000) begin
            err_total++;
            summarize();
        end
    end

    initial forever begin
        @(i_qrc_host_model.byte_ev);
        chk(i_qrc_host_model.got, exp_q.pop_front());
    end

    task automatic mode(input logic pm, input logic q, input logic f);
        @(posedge i_clock);
        #1;
        permit = pm;
        four_wire_command_mode = q;
        fb = f;
    endtask : mode
    task automatic cfg(input logic [2:0] w, input logic [1:0] pr, input logic [2:0] sel);
        @(posedge i_clock);
        #1;
        wbits = w;
        param = pr;
        {rcmd, pload, wload} = sel;
        @(posedge i_clock);
        #1;
        {rcmd, pload, wload} = 3'h0;
        @(posedge i_clock);
        chk(o_wbits, wbits);
    endtask : cfg
    task automatic rd(input logic [7:0] op, input bit wo, input int an, input logic [31:0] ad,
                      input logic [7:0] m, input int dm, input int n, input bit ok);
        logic [31:0] msk;
        int          k;
        msk = {24'h0, (WRAP_MIN_LEN << wbits[2:1]) - 8'h01};
        oe_seen = 1'b0;
        for (k = 0; k < n; k++) begin
            if (!four_wire_command_mode && !wbits[0]) exp_q.push_back(mem_f((ad & ~msk) | ((ad + k) & msk)));
            else exp_q.push_back(mem_f(ad + k));
        end
        i_qrc_host_model.xfer(op, wo, four_wire_command_mode, an, ad, m, dm, n);
        chk(exp_q.size(), 0);
        chk(oe_seen, ok);
        if (ok) chk(o_cont, m[5:4] == OPCODE_SKIP_CODE);
    endtask : rd

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        {i_srst, permit, four_wire_command_mode, fb, wload, pload, rcmd} = 7'h60;
        {mrdy, mval, mdat, param, wbits} = 15'h1;
        lf = 32'h887A8250;
        {err_total, compares, cyc} = 0;
        repeat (16) @(posedge i_clock);
        #1;
        i_srst = 1'b0;
        repeat (4) @(posedge i_clock);
        chk(o_wbits, 3'h1);
        chk(o_cont, 1'b0);
        rd(OP_QUAD_READ, 1, ADDR_CLKS_3B, {8'h00, lf[23:0]}, 8'hF0, DUMMY_QUAD_SPI, 5, 1);
        mode(1'b1, 1'b0, 1'b1);
        rd(OP_QUAD_READ, 1, ADDR_CLKS_4B, lf, 8'h2A, DUMMY_QUAD_SPI, 3, 1);
        rd(OP_QUAD_READ, 0, ADDR_CLKS_4B, lf, 8'h5F, DUMMY_QUAD_SPI, 3, 1);
        mode(1'b1, 1'b0, 1'b0);
        rd(OP_WORD_READ, 1, ADDR_CLKS_3B, {8'h00, lf[23:1], 1'b0}, 8'hA5, DUMMY_WORD_SPI, 4,
           1);
        rd(8'h00, 0, ADDR_CLKS_3B, 32'h111111, 8'h11, 0, 0, 0);
        chk(o_cont, 1'b0);
        cfg(3'h0, 2'h0, 3'h1);
        rd(OP_QUAD_READ, 1, ADDR_CLKS_3B, {8'h00, lf[23:3], 3'h6}, 8'hF0, DUMMY_QUAD_SPI, 10,
           1);
        cfg(3'h2, 2'h3, 3'h3);
        rd(OP_QUAD_READ_4B, 1, ADDR_CLKS_4B, {lf[31:4], 4'hB}, 8'hF0, DUMMY_QUAD_SPI, 20,
           1);
        mode(1'b0, 1'b0, 1'b0);
        rd(OP_QUAD_READ, 1, ADDR_CLKS_3B, lf, 8'hF0, DUMMY_QUAD_SPI, 0, 0);
        rd(OP_WORD_READ, 1, ADDR_CLKS_3B, lf, 8'hF0, DUMMY_WORD_SPI, 0, 0);
        mode(1'b1, 1'b1, 1'b0);
        cfg(3'h1, 2'h0, 3'h4);
        cfg(3'h0, 2'h0, 3'h1);
        for (p = 0; p < 4; p++) begin
            if (p != 0) cfg(wbits, p[1:0], 3'h2);
            rd(OP_QUAD_READ, 1, ADDR_CLKS_3B, {8'h00, lf[23:0]}, 8'hF0, 2 * p, 9, 1);
        end
        rd(OP_QUAD_READ, 1, ADDR_CLKS_3B, {8'h00, lf[23:0]}, 8'h20, 6, 2, 1);
        rd(OP_QUAD_READ, 0, ADDR_CLKS_3B, {8'h00, lf[23:0]}, 8'hFF, 6, 2, 1);
        rd(OP_QUAD_READ_4B, 1, ADDR_CLKS_4B, lf, 8'hF0, 6, 0, 0);
        chk(o_under, 1'b0);
        summarize();
    end
endmodule : qrc_quad_read_tb

bind qrc_quad_read qrc_quad_read_sva i_qrc_quad_read_sva (.i_clock, .i_srst, .i_cs_n,
    .i_sck, .i_quad_io_permit_bit, .i_wrap_load, .i_wrap_setting_bits, .i_reset_cmd,
    .i_mem_req_ready, .o_io, .o_io_oe, .o_mem_req, .o_continuous_read, .o_wrap_setting_bits);
`default_nettype wire
